// *** hw/ubcc_pkg.sv ***
// Purpose: Shared constants and carriers of the user break condition block
// Assumes: Byte offsets on an 8-bit register address port
// Notes:   Field positions follow the qualifier and control register layouts
package ubcc_pkg;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam int unsigned ADDR_W         = 8;
    localparam logic [7:0]  OFS_QUAL_A     = 8'h00;
    localparam logic [7:0]  OFS_QUAL_B     = 8'h04;
    localparam logic [7:0]  OFS_CMP_DATA   = 8'h08;
    localparam logic [7:0]  OFS_DATA_MASK  = 8'h0C;
    localparam logic [7:0]  OFS_CONTROL    = 8'h10;
    localparam logic [7:0]  OFS_AMASK_A    = 8'h14;
    localparam logic [7:0]  OFS_AMASK_B    = 8'h18;
    localparam logic [7:0]  OFS_BADDR_A    = 8'h1C;
    localparam logic [7:0]  OFS_BADDR_B    = 8'h20;

    // ****************************************
    // Reset values and writable bits
    // ****************************************
    localparam logic [5:0]  QUAL_RESET     = 6'h00;
    localparam logic [15:0] QUAL_WMASK     = 16'h003F;
    localparam logic [15:0] CTRL_WMASK     = 16'hC4C8;
    localparam logic [2:0]  AMASK_RESET    = 3'h0;
    localparam logic [31:0] WORD_RESET     = 32'h00000000;

    // ****************************************
    // Control register bit positions
    // ****************************************
    localparam int unsigned CTRL_FLAG_A    = 15;
    localparam int unsigned CTRL_FLAG_B    = 14;
    localparam int unsigned CTRL_TIMING_A  = 10;
    localparam int unsigned CTRL_DATA_EN   = 7;
    localparam int unsigned CTRL_TIMING_B  = 6;
    localparam int unsigned CTRL_CHAIN     = 3;

    // ****************************************
    // Field encodings
    // ****************************************
    localparam logic [1:0]  CYC_OFF        = 2'h0;
    localparam logic [1:0]  CYC_FETCH      = 2'h1;
    localparam logic [1:0]  CYC_DATA       = 2'h2;
    localparam logic [1:0]  DIR_OFF        = 2'h0;
    localparam logic [1:0]  DIR_READ       = 2'h1;
    localparam logic [1:0]  DIR_WRITE      = 2'h2;
    localparam logic [1:0]  SIZE_ANY       = 2'h0;
    localparam logic [1:0]  SIZE_BYTE      = 2'h1;
    localparam logic [1:0]  SIZE_WORD      = 2'h2;
    localparam logic [1:0]  SIZE_LONG      = 2'h3;
    localparam logic [1:0]  AMASK_LO10     = 2'h1;
    localparam logic [1:0]  AMASK_LO12     = 2'h2;
    localparam logic [1:0]  AMASK_ALL      = 2'h3;
    localparam logic [31:0] LO10_BITS      = 32'h000003FF;
    localparam logic [31:0] LO12_BITS      = 32'h00000FFF;
    localparam logic [31:0] ALL_BITS       = 32'hFFFFFFFF;
    localparam logic [31:0] WORD_LOW_BITS  = 32'h00000001;
    localparam logic [31:0] LONG_LOW_BITS  = 32'h00000003;
    localparam logic [31:0] UPPER16_BITS   = 32'hFFFF0000;

    // Qualifier fields, laid out as bits 5..0
    typedef struct packed {
        logic [1:0] cyc;
        logic [1:0] dir;
        logic [1:0] size;
    } ubcc_qual_s;

    // One processor bus cycle as seen by the break logic
    typedef struct packed {
        logic        valid;
        logic        fetch;
        logic        write;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] data;
    } ubcc_cycle_s;

    // Trap request toward the core
    typedef struct packed {
        logic req;
        logic after;
    } ubcc_trap_s;

endpackage

// *** hw/ubcc_chan_match.sv ***
// Purpose: Bus cycle and address match of one break channel
// Assumes: Cycle fields are stable while valid is high
// Notes:   Data compare is left to the caller
`timescale 1ns/1ps
`default_nettype none
module ubcc_chan_match (
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_resetn,
    input  wire ubcc_pkg::ubcc_qual_s   i_qual,
    input  wire logic [1:0]             i_amask,
    input  wire logic [31:0]            i_baddr,
    input  wire ubcc_pkg::ubcc_cycle_s  i_cycle,
    output logic                        o_hit
);

    // ****************************************
    // Address bits left out of the compare
    // ****************************************
    function automatic logic [31:0] skip_bits(input logic [1:0] am, input logic [1:0] sz, input logic dat);
        logic [31:0] m;
        m = 32'h00000000;
        if (am == ubcc_pkg::AMASK_LO10) m = ubcc_pkg::LO10_BITS;
        if (am == ubcc_pkg::AMASK_LO12) m = ubcc_pkg::LO12_BITS;
        if (am == ubcc_pkg::AMASK_ALL)  m = ubcc_pkg::ALL_BITS;
        if (dat && sz == ubcc_pkg::SIZE_WORD) m = m | ubcc_pkg::WORD_LOW_BITS;
        if (dat && sz == ubcc_pkg::SIZE_LONG) m = m | ubcc_pkg::LONG_LOW_BITS;
        return m;
    endfunction

    logic [1:0]  eff_size;
    logic        type_ok;
    logic        dir_ok;
    logic        size_ok;
    logic        addr_ok;

    // Qualifier decode
    always_comb begin
        eff_size = (i_qual.size == ubcc_pkg::SIZE_ANY) ? i_cycle.size : i_qual.size;
        type_ok  = (i_qual.cyc[0] && i_cycle.fetch) || (i_qual.cyc[1] && !i_cycle.fetch);
        dir_ok   = (i_qual.dir[0] && !i_cycle.write) || (i_qual.dir[1] && i_cycle.write);
        size_ok  = (i_qual.size == ubcc_pkg::SIZE_ANY) || (i_qual.size == i_cycle.size);
        addr_ok  = ((i_cycle.addr ^ i_baddr)
                    & ~skip_bits(i_amask, eff_size, !i_cycle.fetch)) == 32'h00000000;
        o_hit    = i_cycle.valid && type_ok && dir_ok && size_ok && addr_ok;
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    AST_CYC_OFF: assert property (i_qual.cyc == ubcc_pkg::CYC_OFF |-> !o_hit)
        else $error("channel hit with cycle type off");
    AST_DIR_OFF: assert property (i_qual.dir == ubcc_pkg::DIR_OFF |-> !o_hit)
        else $error("channel hit with direction off");
    AST_SIZE_EQ: assert property (o_hit && i_qual.size != ubcc_pkg::SIZE_ANY |-> i_cycle.size == i_qual.size)
        else $error("channel hit with wrong size");
    AST_ADDR_FULL: assert property (o_hit && i_amask == 2'h0 && i_cycle.fetch |-> i_cycle.addr == i_baddr)
        else $error("unmasked fetch hit on other address");

endmodule
`default_nettype wire

// *** hw/ubcc_top.sv ***
// Purpose: Two-channel user break condition logic with register port
// Assumes: Bus cycles and manual reset come from the core clock domain
// Notes:   Power-on reset is i_resetn, manual reset a synchronous level
//
// Contract
// - Channel A qualifier clears on both resets
// - Reserved bits read zero, written zero
// - Cycle type: off, fetch, data, either
// - Direction: off, read, write, both
// - Size: any, byte, word, longword
// - Channel B qualifier mirrors channel A
// - Channel B address mask mirrors channel A
// - Compare data survives manual reset
// - Data mask survives manual reset
// - Mask bit one drops that data bit
// - Byte or word ignores upper sixteen bits
// - Data ignored for fetch or compare disabled
// - Control register clears on both resets
// - Channel A flag set by hardware, cleared by software
// - Channel B flag sticky until software clears
// - Channel A timing: before or after execution
// - Channel B timing: before or after execution
// - Data compare enable adds data to B
// - Chaining: B counts only after A matched
// - Address mask: none, low ten, low twelve, all
// - Chained: no break on early B; B flag only
// - Data access skips low address bits by size
`timescale 1ns/1ps
`default_nettype none
module ubcc_top (
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_resetn,
    input  wire logic                   i_manual_reset,
    input  wire logic [7:0]             i_addr,
    input  wire logic [31:0]            i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    output logic [31:0]                 o_rdata,
    input  wire ubcc_pkg::ubcc_cycle_s  i_cycle,
    output ubcc_pkg::ubcc_trap_s        o_trap
);

    // ****************************************
    // Register state
    // ****************************************
    ubcc_pkg::ubcc_qual_s  qual_a_reg;
    ubcc_pkg::ubcc_qual_s  qual_b_reg;
    logic [31:0]           cmp_data_reg;
    logic [31:0]           data_mask_reg;
    logic [2:0]            amask_a_reg;
    logic [2:0]            amask_b_reg;
    logic [31:0]           baddr_a_reg;
    logic [31:0]           baddr_b_reg;
    logic                  flag_a_reg;
    logic                  flag_b_reg;
    logic                  timing_a_reg;
    logic                  timing_b_reg;
    logic                  data_en_reg;
    logic                  chain_reg;
    logic                  a_seen_reg;
    logic [31:0]           rdata_reg;
    logic                  flag_a_next;
    logic                  flag_b_next;
    logic                  a_seen_next;
    logic                  a_hit;
    logic                  b_addr_hit;
    logic                  b_hit;
    logic                  data_ok;
    logic                  a_set;
    logic                  b_set;
    logic                  ctl_wr;
    logic [31:0]           eff_mask;

    // Write strobe for one offset
    function automatic logic wr_at(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
        return wr && (a == ofs);
    endfunction

    // Control register image, reserved bits zero
    function automatic logic [15:0] ctrl_image(input logic fa, input logic fb, input logic ta,
                                               input logic de, input logic tb, input logic ch);
        logic [15:0] v;
        v = 16'h0000;
        v[ubcc_pkg::CTRL_FLAG_A]   = fa;
        v[ubcc_pkg::CTRL_FLAG_B]   = fb;
        v[ubcc_pkg::CTRL_TIMING_A] = ta;
        v[ubcc_pkg::CTRL_DATA_EN]  = de;
        v[ubcc_pkg::CTRL_TIMING_B] = tb;
        v[ubcc_pkg::CTRL_CHAIN]    = ch;
        return v;
    endfunction

    assign ctl_wr = wr_at(i_wr, i_addr, ubcc_pkg::OFS_CONTROL);

    // ****************************************
    // Channel match
    // ****************************************
    ubcc_chan_match u_match_a (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_qual    (qual_a_reg),
        .i_amask   (amask_a_reg[1:0]),
        .i_baddr   (baddr_a_reg),
        .i_cycle   (i_cycle),
        .o_hit     (a_hit)
    );

    // Channel B uses the same qualifier and address mask logic
    ubcc_chan_match u_match_b (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_qual    (qual_b_reg),
        .i_amask   (amask_b_reg[1:0]),
        .i_baddr   (baddr_b_reg),
        .i_cycle   (i_cycle),
        .o_hit     (b_addr_hit)
    );

    // Channel B data compare
    always_comb begin
        eff_mask = data_mask_reg;
        if (qual_b_reg.size == ubcc_pkg::SIZE_BYTE || qual_b_reg.size == ubcc_pkg::SIZE_WORD) begin
            eff_mask = data_mask_reg | ubcc_pkg::UPPER16_BITS;
        end
        data_ok = ((i_cycle.data ^ cmp_data_reg) & ~eff_mask) == 32'h00000000;
        if (i_cycle.fetch || qual_b_reg.cyc == ubcc_pkg::CYC_FETCH || !data_en_reg) begin
            data_ok = 1'b1;
        end
        b_hit = b_addr_hit && data_ok;
    end

    // Independent or chained setting of the flags
    always_comb begin
        a_set       = a_hit && !chain_reg;
        b_set       = b_hit && (!chain_reg || a_seen_reg);
        a_seen_next = chain_reg && (a_hit || (a_seen_reg && !b_set));
        flag_a_next = a_set
                      || (flag_a_reg && !(ctl_wr && !i_wdata[ubcc_pkg::CTRL_FLAG_A]));
        flag_b_next = b_set
                      || (flag_b_reg && !(ctl_wr && !i_wdata[ubcc_pkg::CTRL_FLAG_B]));
    end

    // Trap request toward the core, a before break wins
    always_comb begin
        o_trap.req   = a_set || b_set;
        o_trap.after = (!a_set || !i_cycle.fetch || timing_a_reg)
                       && (!b_set || !i_cycle.fetch || timing_b_reg);
    end

    // ****************************************
    // Registers cleared by either reset
    // ****************************************

    // Bus cycle qualifiers
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            qual_a_reg <= ubcc_pkg::QUAL_RESET;
            qual_b_reg <= ubcc_pkg::QUAL_RESET;
        end else if (i_manual_reset) begin
            qual_a_reg <= ubcc_pkg::QUAL_RESET;
            qual_b_reg <= ubcc_pkg::QUAL_RESET;
        end else begin
            if (wr_at(i_wr, i_addr, ubcc_pkg::OFS_QUAL_A)) begin
                qual_a_reg <= i_wdata[5:0];
            end
            if (wr_at(i_wr, i_addr, ubcc_pkg::OFS_QUAL_B)) begin
                qual_b_reg <= i_wdata[5:0];
            end
        end
    end

    // Control bits
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            timing_a_reg <= 1'b0;
            timing_b_reg <= 1'b0;
            data_en_reg  <= 1'b0;
            chain_reg    <= 1'b0;
        end else if (i_manual_reset) begin
            timing_a_reg <= 1'b0;
            timing_b_reg <= 1'b0;
            data_en_reg  <= 1'b0;
            chain_reg    <= 1'b0;
        end else if (ctl_wr) begin
            timing_a_reg <= i_wdata[ubcc_pkg::CTRL_TIMING_A];
            timing_b_reg <= i_wdata[ubcc_pkg::CTRL_TIMING_B];
            data_en_reg  <= i_wdata[ubcc_pkg::CTRL_DATA_EN];
            chain_reg    <= i_wdata[ubcc_pkg::CTRL_CHAIN];
        end
    end

    // Match flags and chain arming
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            flag_a_reg <= 1'b0;
            flag_b_reg <= 1'b0;
            a_seen_reg <= 1'b0;
        end else if (i_manual_reset) begin
            flag_a_reg <= 1'b0;
            flag_b_reg <= 1'b0;
            a_seen_reg <= 1'b0;
        end else begin
            flag_a_reg <= flag_a_next;
            flag_b_reg <= flag_b_next;
            a_seen_reg <= a_seen_next;
        end
    end

    // ****************************************
    // Registers kept over manual reset
    // ****************************************

    // Data compare and mask words
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cmp_data_reg  <= ubcc_pkg::WORD_RESET;
            data_mask_reg <= ubcc_pkg::WORD_RESET;
        end else begin
            if (wr_at(i_wr, i_addr, ubcc_pkg::OFS_CMP_DATA)) begin
                cmp_data_reg <= i_wdata;
            end
            if (wr_at(i_wr, i_addr, ubcc_pkg::OFS_DATA_MASK)) begin
                data_mask_reg <= i_wdata;
            end
        end
    end

    // Break addresses and address masks
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            amask_a_reg <= ubcc_pkg::AMASK_RESET;
            amask_b_reg <= ubcc_pkg::AMASK_RESET;
            baddr_a_reg <= ubcc_pkg::WORD_RESET;
            baddr_b_reg <= ubcc_pkg::WORD_RESET;
        end else begin
            if (wr_at(i_wr, i_addr, ubcc_pkg::OFS_AMASK_A)) begin
                amask_a_reg <= i_wdata[2:0];
            end
            if (wr_at(i_wr, i_addr, ubcc_pkg::OFS_AMASK_B)) begin
                amask_b_reg <= i_wdata[2:0];
            end
            if (wr_at(i_wr, i_addr, ubcc_pkg::OFS_BADDR_A)) begin
                baddr_a_reg <= i_wdata;
            end
            if (wr_at(i_wr, i_addr, ubcc_pkg::OFS_BADDR_B)) begin
                baddr_b_reg <= i_wdata;
            end
        end
    end

    // ****************************************
    // Read port, data one cycle after the strobe
    // ****************************************
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_reg <= 32'h00000000;
        end else if (!i_rd) begin
            rdata_reg <= 32'h00000000;
        end else begin
            case (i_addr)
                ubcc_pkg::OFS_QUAL_A:    rdata_reg <= {26'h0000000, qual_a_reg};
                ubcc_pkg::OFS_QUAL_B:    rdata_reg <= {26'h0000000, qual_b_reg};
                ubcc_pkg::OFS_CMP_DATA:  rdata_reg <= cmp_data_reg;
                ubcc_pkg::OFS_DATA_MASK: rdata_reg <= data_mask_reg;
                ubcc_pkg::OFS_CONTROL:   rdata_reg <= {16'h0000, ctrl_image(flag_a_reg, flag_b_reg,
                                             timing_a_reg, data_en_reg, timing_b_reg, chain_reg)};
                ubcc_pkg::OFS_AMASK_A:   rdata_reg <= {29'h00000000, amask_a_reg};
                ubcc_pkg::OFS_AMASK_B:   rdata_reg <= {29'h00000000, amask_b_reg};
                ubcc_pkg::OFS_BADDR_A:   rdata_reg <= baddr_a_reg;
                ubcc_pkg::OFS_BADDR_B:   rdata_reg <= baddr_b_reg;
                default:                 rdata_reg <= 32'h00000000;
            endcase
        end
    end

    assign o_rdata = rdata_reg;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    AST_QUAL_MRESET: assert property (i_manual_reset |=> qual_a_reg == 6'h00 && qual_b_reg == 6'h00)
        else $error("qualifiers not cleared by manual reset");
    AST_CTRL_MRESET: assert property (i_manual_reset |=> !flag_a_reg && !flag_b_reg && !chain_reg && !data_en_reg)
        else $error("control not cleared by manual reset");
    AST_DATA_KEEP: assert property (i_manual_reset && !i_wr |=> $stable(cmp_data_reg) && $stable(data_mask_reg))
        else $error("data words lost on manual reset");
    AST_RSVD_CTRL: assert property (i_rd && i_addr == ubcc_pkg::OFS_CONTROL |=> o_rdata[31:16] == 16'h0000
                                    && (o_rdata[15:0] & ~ubcc_pkg::CTRL_WMASK) == 16'h0000)
        else $error("reserved control bits read nonzero");
    AST_FLAG_A_STICKY: assert property (flag_a_reg && !i_manual_reset && !ctl_wr |=> flag_a_reg)
        else $error("channel A flag dropped without a write");
    AST_FLAG_B_SET: assert property (b_set && !i_manual_reset |=> flag_b_reg ##1
                                     (flag_b_reg || $past(i_manual_reset)
                                      || $past(ctl_wr && !i_wdata[ubcc_pkg::CTRL_FLAG_B])))
        else $error("channel B flag not held after match");
    AST_CHAIN_EARLY: assert property (chain_reg && !a_seen_reg |-> !o_trap.req)
        else $error("chained break before channel A");
    AST_TRAP_FLAG: assert property (o_trap.req && !i_manual_reset |=> flag_a_reg || flag_b_reg)
        else $error("trap without a flag");
    AST_NO_DATA: assert property (b_addr_hit && !data_en_reg && !chain_reg |-> o_trap.req)
        else $error("data compared while disabled");
    AST_TIMING_A: assert property (a_set && !b_set && i_cycle.fetch |-> o_trap.after == timing_a_reg)
        else $error("channel A timing wrong");

    COV_CHAINED: cover property (chain_reg && a_hit ##[1:20] b_set);
    COV_DATA_BRK: cover property (data_en_reg && b_set && !i_cycle.fetch);
    COV_FETCH_A: cover property (a_set && i_cycle.fetch && timing_a_reg);
    COV_FLAG_CLR: cover property (flag_a_reg ##1 !flag_a_reg);

endmodule
`default_nettype wire

// *** tb/ubcc_core_model.sv ***
// Purpose: Core-side model that issues processor bus cycles
// Assumes: One cycle per call, launched just after a rising edge
// Notes:   Released fields show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module ubcc_core_model (
    output ubcc_pkg::ubcc_cycle_s o_cycle,
    input  wire logic             i_ref_clk
);
    // Idle bus until the first cycle
    initial o_cycle = '0;

    // Present one bus cycle for one clock
    task automatic drive(input logic f, input logic w, input logic [1:0] s, input logic [31:0] a,
                         input logic [31:0] d);
        @(posedge i_ref_clk);
        o_cycle <= {1'b1, f, w, s, a, d};
    endtask

    // Drop valid; stale fields must not look like a live cycle
    task automatic idle();
        @(posedge i_ref_clk);
        o_cycle <= {1'b0, ~o_cycle[67:0]};
    endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: Self-checking bench of the user break condition block
// Assumes: Register port and bus cycle timing as handed over
// Notes:   One task a scenario; core cycles come from the model
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                  i_ref_clk      = 1'b0;
    logic                  i_resetn       = 1'b0;
    logic                  i_manual_reset = 1'b0;
    logic [7:0]            i_addr         = 8'h00;
    logic [31:0]           i_wdata        = 32'h0;
    logic                  i_wr           = 1'b0;
    logic                  i_rd           = 1'b0;
    logic [31:0]           o_rdata;
    ubcc_pkg::ubcc_cycle_s cyc;
    ubcc_pkg::ubcc_trap_s  o_trap;
    int                    n_fail         = 0;
    int                    checked        = 0;

    // Clock at 100 MHz
    always #5 i_ref_clk = ~i_ref_clk;

    ubcc_top dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_manual_reset(i_manual_reset), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cycle(cyc), .o_trap(o_trap));
    ubcc_core_model core (.o_cycle(cyc), .i_ref_clk(i_ref_clk));

    // Compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask

    // One-cycle register read, data judged in the following cycle
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        @(negedge i_ref_clk);
        chk("rdata", o_rdata, exp);
    endtask

    // One bus cycle; trap judged in the same cycle, after bit only when a trap is due
    task automatic bus(input logic f, input logic w, input logic [1:0] s, input logic [31:0] a,
                       input logic [31:0] d, input logic [1:0] exp);
        core.drive(f, w, s, a, d);
        @(negedge i_ref_clk);
        chk("trap", {30'h0, o_trap.req, o_trap.after & exp[1]}, {30'h0, exp});
        core.idle();
    endtask

    // Reset values and reserved bits
    task automatic t_regs();
        rd(ubcc_pkg::OFS_QUAL_A, 32'h0);
        rd(ubcc_pkg::OFS_QUAL_B, 32'h0);
        rd(ubcc_pkg::OFS_CONTROL, 32'h0);
        wr(ubcc_pkg::OFS_QUAL_A, 32'h3F);
        rd(ubcc_pkg::OFS_QUAL_A, 32'h3F);
        wr(ubcc_pkg::OFS_CONTROL, 32'h04C8);
        rd(ubcc_pkg::OFS_CONTROL, 32'h04C8);
        rd(8'hFC, 32'h0);
        wr(ubcc_pkg::OFS_CONTROL, 32'h0);
        $display("test regs done");
    endtask

    // Channel A fetch breaks, flag and address mask
    task automatic t_fetch();
        wr(ubcc_pkg::OFS_BADDR_A, 32'h404);
        wr(ubcc_pkg::OFS_AMASK_A, 32'h0);
        wr(ubcc_pkg::OFS_CONTROL, 32'h0400);
        wr(ubcc_pkg::OFS_QUAL_A, 32'h14);
        bus(1'b1, 1'b0, 2'h3, 32'h404, 32'h0, 2'h3);
        rd(ubcc_pkg::OFS_CONTROL, 32'h8400);
        bus(1'b1, 1'b0, 2'h3, 32'h408, 32'h0, 2'h0);
        bus(1'b0, 1'b0, 2'h3, 32'h404, 32'h0, 2'h0);
        wr(ubcc_pkg::OFS_CONTROL, 32'h0);
        rd(ubcc_pkg::OFS_CONTROL, 32'h0);
        wr(ubcc_pkg::OFS_AMASK_A, 32'h1);
        bus(1'b1, 1'b0, 2'h3, 32'h7FC, 32'h0, 2'h2);
        rd(ubcc_pkg::OFS_CONTROL, 32'h8000);
        wr(ubcc_pkg::OFS_CONTROL, 32'h0);
        $display("test fetch done");
    endtask

    // Channel B data compare, mask, size and enable
    task automatic t_data();
        wr(ubcc_pkg::OFS_BADDR_B, 32'h1000);
        wr(ubcc_pkg::OFS_AMASK_B, 32'h0);
        wr(ubcc_pkg::OFS_CMP_DATA, 32'h12345678);
        wr(ubcc_pkg::OFS_DATA_MASK, 32'hFF);
        wr(ubcc_pkg::OFS_CONTROL, 32'h80);
        wr(ubcc_pkg::OFS_QUAL_B, 32'h2B);
        bus(1'b0, 1'b1, 2'h3, 32'h1000, 32'h123456AA, 2'h3);
        bus(1'b0, 1'b1, 2'h3, 32'h1000, 32'h02345678, 2'h0);
        bus(1'b0, 1'b0, 2'h3, 32'h1000, 32'h12345678, 2'h0);
        rd(ubcc_pkg::OFS_CONTROL, 32'h4080);
        wr(ubcc_pkg::OFS_CMP_DATA, 32'hFFFF5678);
        wr(ubcc_pkg::OFS_DATA_MASK, 32'hF);
        wr(ubcc_pkg::OFS_QUAL_B, 32'h2A);
        bus(1'b0, 1'b1, 2'h2, 32'h1001, 32'h0000567F, 2'h3);
        bus(1'b0, 1'b1, 2'h3, 32'h1000, 32'h00005678, 2'h0);
        wr(ubcc_pkg::OFS_CMP_DATA, 32'h00007878);
        wr(ubcc_pkg::OFS_DATA_MASK, 32'h00000F0F);
        wr(ubcc_pkg::OFS_QUAL_B, 32'h29);
        bus(1'b0, 1'b1, 2'h1, 32'h1000, 32'h0000787A, 2'h3);
        wr(ubcc_pkg::OFS_AMASK_B, 32'h3);
        bus(1'b0, 1'b1, 2'h1, 32'h5000, 32'h00007878, 2'h3);
        wr(ubcc_pkg::OFS_AMASK_B, 32'h0);
        wr(ubcc_pkg::OFS_CONTROL, 32'h0);
        bus(1'b0, 1'b1, 2'h1, 32'h1000, 32'hDEAD0000, 2'h3);
        $display("test data done");
    endtask

    // Chained channels: early B ignored, A silent, B after A breaks
    task automatic t_chain();
        wr(ubcc_pkg::OFS_CONTROL, 32'h0);
        wr(ubcc_pkg::OFS_BADDR_B, 32'h800);
        wr(ubcc_pkg::OFS_QUAL_B, 32'h14);
        wr(ubcc_pkg::OFS_CONTROL, 32'h8);
        bus(1'b1, 1'b0, 2'h3, 32'h800, 32'h0, 2'h0);
        bus(1'b1, 1'b0, 2'h3, 32'h404, 32'h0, 2'h0);
        bus(1'b1, 1'b0, 2'h3, 32'h800, 32'h0, 2'h2);
        rd(ubcc_pkg::OFS_CONTROL, 32'h4008);
        $display("test chain done");
    endtask

    // Manual reset clears qualifiers and control, keeps data and mask
    task automatic t_mreset();
        @(posedge i_ref_clk);
        i_manual_reset <= 1'b1;
        @(posedge i_ref_clk);
        i_manual_reset <= 1'b0;
        rd(ubcc_pkg::OFS_QUAL_A, 32'h0);
        rd(ubcc_pkg::OFS_QUAL_B, 32'h0);
        rd(ubcc_pkg::OFS_CONTROL, 32'h0);
        rd(ubcc_pkg::OFS_CMP_DATA, 32'h00007878);
        rd(ubcc_pkg::OFS_DATA_MASK, 32'h00000F0F);
        bus(1'b1, 1'b0, 2'h3, 32'h404, 32'h0, 2'h0);
        $display("test manual reset done");
    endtask

    // Counts, verdict and end of run
    task automatic end_sim();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        t_regs();
        t_fetch();
        t_data();
        t_chain();
        t_mreset();
        end_sim();
    end

    // Watchdog well beyond the roughly 125 cycles the tests need
    initial begin
        #50000;
        n_fail++;
        end_sim();
    end
endmodule
`default_nettype wire
